// >>> core/pio_ports.sv
// Purpose: General-purpose ports A to D with peripheral pin sharing.
// Assumes: One clock, synchronous active-high reset, Wishbone classic.
// Notes:   Pin inputs are double-flopped before any read path sees them.
//
// Summary of operation
// - Direction one drives latch, zero floats pin.
// - Reset clears A, B, C, D directions and clock enable.
// - Reset leaves data latches untouched.
// - Port A read muxes latch or pin.
// - Port B read muxes latch or pin.
// - Port C read muxes latch or pin.
// - Latch writes always land, whatever direction.
// - Widths are seven, eight, five, two pins.
// - Converter selection takes pin from timer.
// - Converter pin reads zero when input.
// - Converter pin ignores direction for drive.
// - Timer B select claims upper port B pins.
// - Timer A select claims port D pins.
// - Timer pins: direction only steers read.
// - Port C bit seven drives clock on pin two.
// - Port D read muxes latch or pin.
`timescale 1ns/1ps

module pio_ports
(
   // Clock, reset and enable.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Wishbone slave.
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Peripheral sharing controls.
   input  wire logic [4:0]  converter_channel_select_i,
   input  wire logic        converter_active_i,
   input  wire logic [1:0]  timer_b_edge_level_select_i,
   input  wire logic [1:0]  timer_a_edge_level_select_i,
   input  wire logic [1:0]  timer_b_channel_pins_out_i,
   input  wire logic [1:0]  timer_a_channel_pins_out_i,
   input  wire logic [1:0]  timer_b_channel_pins_oe_i,
   input  wire logic [1:0]  timer_a_channel_pins_oe_i,
   input  wire logic        sys_clk_level_i,
   // Pins.
   input  wire logic [6:0]  pin_a_i,
   input  wire logic [7:0]  pin_b_i,
   input  wire logic [4:0]  pin_c_i,
   input  wire logic [1:0]  pin_d_i,
   output logic      [6:0]  pin_a_o,
   output logic      [6:0]  pin_a_oe_o,
   output logic      [7:0]  pin_b_o,
   output logic      [7:0]  pin_b_oe_o,
   output logic      [4:0]  pin_c_o,
   output logic      [4:0]  pin_c_oe_o,
   output logic      [1:0]  pin_d_o,
   output logic      [1:0]  pin_d_oe_o,
   output logic      [7:0]  converter_pin_sel_o,
   output logic      [1:0]  timer_b_pin_level_o,
   output logic      [1:0]  timer_a_pin_level_o
);

   // Data latches, deliberately without reset.
   logic [6:0] port_a_pin_latch;
   logic [7:0] port_b_pin_latch;
   logic [4:0] port_c_pin_latch;
   logic [1:0] port_d_pin_latch;
   // Direction registers.
   logic [6:0] port_a_direction;
   logic [7:0] port_b_direction;
   logic [4:0] port_c_direction;
   logic [1:0] port_d_direction;
   logic       clock_output_enable;
   // Synchronisers.
   logic [21:0] sync1;
   logic [21:0] sync2;
   logic [6:0]  a_s;
   logic [7:0]  b_s;
   logic [4:0]  c_s;
   logic [1:0]  d_s;
   // Decode.
   logic       req;
   logic       wr;
   logic [7:0] idx;
   logic [7:0] conv_sel;
   logic [7:0] next_b_read;
   pio_pkg::pio_drive_type drv_b;

   assign req = cyc_i & stb_i & ~ack_o;
   // A write lands at the edge where the master samples ack high.
   assign wr  = cyc_i & stb_i & ack_o & we_i & sel_i[0];
   assign idx = adr_i[9:2];

   // Decodes a channel number into a one-hot port B pin select.
   function automatic logic [7:0] chan_dec(input logic [4:0] ch,
                                           input logic act);
      logic [7:0] r;
      r = 8'h00;
      if (act && ch < 5'h08)
      begin
         r[ch[2:0]] = 1'b1;
      end
      return r;
   endfunction

   // Picks latch where direction is output, else the synced pin.
   function automatic logic [7:0] rd_mux(input logic [7:0] lat,
                                         input logic [7:0] pin,
                                         input logic [7:0] dir);
      return (lat & dir) | (pin & ~dir);
   endfunction

   assign conv_sel = chan_dec(converter_channel_select_i,
                              converter_active_i);

   // Two-stage pin synchroniser; only the second stage is read.
   always_ff @(posedge clk_i)
   begin
      if (ce_i)
      begin
         sync1 <= {pin_d_i, pin_c_i, pin_b_i, pin_a_i};
         sync2 <= sync1;
      end
   end
   assign {d_s, c_s, b_s, a_s} = sync2;

   // Data latches take every write and ignore reset.
   always_ff @(posedge clk_i)
   begin
      if (ce_i && wr)
      begin
         case (idx)
            pio_pkg::IDX_PORT_A_LATCH: port_a_pin_latch <= dat_i[6:0];
            pio_pkg::IDX_PORT_B_LATCH: port_b_pin_latch <= dat_i[7:0];
            pio_pkg::IDX_PORT_C_LATCH: port_c_pin_latch <= dat_i[4:0];
            pio_pkg::IDX_PORT_D_LATCH: port_d_pin_latch <= dat_i[1:0];
            default: ;
         endcase
      end
   end

   // Direction registers clear at reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         port_a_direction    <= pio_pkg::DIR_RESET[6:0];
         port_b_direction    <= pio_pkg::DIR_RESET;
         port_c_direction    <= pio_pkg::DIR_RESET[4:0];
         clock_output_enable <= 1'b0;
         port_d_direction    <= pio_pkg::DIR_RESET[1:0];
      end
      else if (ce_i && wr)
      begin
         case (idx)
            pio_pkg::IDX_PORT_A_DIR: port_a_direction <= dat_i[6:0];
            pio_pkg::IDX_PORT_B_DIR: port_b_direction <= dat_i[7:0];
            pio_pkg::IDX_PORT_C_DIR:
            begin
               port_c_direction    <= dat_i[4:0];
               clock_output_enable <= dat_i[pio_pkg::CLK_OUT_BIT];
            end
            pio_pkg::IDX_PORT_D_DIR: port_d_direction <= dat_i[1:0];
            default: ;
         endcase
      end
   end

   // Port B read: converter pins read zero when input.
   always_comb
   begin
      next_b_read = rd_mux(port_b_pin_latch, b_s, port_b_direction);
      next_b_read = next_b_read & ~(conv_sel & ~port_b_direction);
   end

   // Bus answer one cycle after the request, unmapped reads zero.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         ack_o <= req;
         dat_o <= 32'h0000_0000;
         if (req && !we_i)
         begin
            case (idx)
               pio_pkg::IDX_PORT_A_LATCH:
                  dat_o[7:0] <= rd_mux({1'b0, port_a_pin_latch}, {1'b0, a_s},
                                       {1'b0, port_a_direction});
               pio_pkg::IDX_PORT_B_LATCH: dat_o[7:0] <= next_b_read;
               pio_pkg::IDX_PORT_C_LATCH:
                  dat_o[7:0] <= rd_mux({3'h0, port_c_pin_latch}, {3'h0, c_s},
                                       {3'h0, port_c_direction});
               pio_pkg::IDX_PORT_D_LATCH:
                  dat_o[7:0] <= rd_mux({6'h00, port_d_pin_latch}, {6'h00, d_s},
                                       {6'h00, port_d_direction});
               pio_pkg::IDX_PORT_A_DIR: dat_o[6:0] <= port_a_direction;
               pio_pkg::IDX_PORT_B_DIR: dat_o[7:0] <= port_b_direction;
               pio_pkg::IDX_PORT_C_DIR:
                  dat_o[7:0] <= {clock_output_enable, 2'b00, port_c_direction};
               pio_pkg::IDX_PORT_D_DIR: dat_o[1:0] <= port_d_direction;
               default: dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Port B drive: converter beats timer beats plain port.
   always_comb
   begin
      drv_b.oe  = port_b_direction & ~conv_sel;
      drv_b.out = port_b_pin_latch;
      for (int i = 0; i < 2; i++)
      begin
         if (timer_b_edge_level_select_i[i]
             && !conv_sel[pio_pkg::TIMER_B_LSB + i])
         begin
            drv_b.oe[pio_pkg::TIMER_B_LSB + i]  = timer_b_channel_pins_oe_i[i];
            drv_b.out[pio_pkg::TIMER_B_LSB + i] = timer_b_channel_pins_out_i[i];
         end
      end
   end

   // Registered pin drivers.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_a_oe_o <= 7'h00;
         pin_b_oe_o <= 8'h00;
         pin_c_oe_o <= 5'h00;
         pin_d_oe_o <= 2'h0;
         pin_a_o    <= 7'h00;
         pin_b_o    <= 8'h00;
         pin_c_o    <= 5'h00;
         pin_d_o    <= 2'h0;
      end
      else if (ce_i)
      begin
         pin_a_oe_o <= port_a_direction;
         pin_a_o    <= port_a_pin_latch;
         pin_b_oe_o <= drv_b.oe;
         pin_b_o    <= drv_b.out;
         pin_c_oe_o <= port_c_direction;
         pin_c_o    <= port_c_pin_latch;
         if (clock_output_enable)
         begin
            pin_c_oe_o[pio_pkg::CLK_OUT_PIN] <= 1'b1;
            pin_c_o[pio_pkg::CLK_OUT_PIN]    <= sys_clk_level_i;
         end
         for (int i = 0; i < 2; i++)
         begin
            if (timer_a_edge_level_select_i[i])
            begin
               pin_d_oe_o[i] <= timer_a_channel_pins_oe_i[i];
               pin_d_o[i]    <= timer_a_channel_pins_out_i[i];
            end
            else
            begin
               pin_d_oe_o[i] <= port_d_direction[i];
               pin_d_o[i]    <= port_d_pin_latch[i];
            end
         end
      end
   end

   // Peripheral-side views of the pins.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         converter_pin_sel_o <= 8'h00;
         timer_b_pin_level_o <= 2'h0;
         timer_a_pin_level_o <= 2'h0;
      end
      else if (ce_i)
      begin
         converter_pin_sel_o <= conv_sel;
         timer_b_pin_level_o <= b_s[7:6] & timer_b_edge_level_select_i
                                & ~conv_sel[7:6];
         timer_a_pin_level_o <= d_s & timer_a_edge_level_select_i;
      end
   end

   // Port A, B and C direction bits and the clock enable clear after reset.
   property p_dir_reset;
      @(posedge clk_i) rst_i |=> (port_a_direction == 7'h00
         && port_b_direction == 8'h00 && port_c_direction == 5'h00
         && !clock_output_enable);
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("dir not cleared");

   // Plain port A pins follow direction one cycle on.
   property p_a_oe;
      @(posedge clk_i) disable iff (rst_i)
      ce_i ##1 ce_i |-> pin_a_oe_o == $past(port_a_direction);
   endproperty
   a_a_oe: assert property (p_a_oe) else $error("port a oe wrong");

   // Latch write lands whatever direction.
   property p_latch_wr;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && idx == 8'h00) |=> port_a_pin_latch == $past(dat_i[6:0]);
   endproperty
   a_latch_wr: assert property (p_latch_wr) else $error("latch write lost");

   // Clock enable bit forces pin two driven.
   property p_clk_out;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && clock_output_enable) |=> pin_c_oe_o[2];
   endproperty
   a_clk_out: assert property (p_clk_out) else $error("clock pin not driven");

   // A converter-selected pin is never driven.
   property p_conv;
      @(posedge clk_i) disable iff (rst_i)
      ce_i |-> (drv_b.oe & conv_sel) == 8'h00;
   endproperty
   a_conv: assert property (p_conv) else $error("converter pin driven");

   // Converter input pin reads zero.
   property p_conv_rd;
      @(posedge clk_i) disable iff (rst_i)
      ((next_b_read & conv_sel & ~port_b_direction) == 8'h00);
   endproperty
   a_conv_rd: assert property (p_conv_rd) else $error("converter read nonzero");

   // Synchroniser delays the pin exactly two cycles.
   property p_sync;
      @(posedge clk_i) disable iff (rst_i)
      ce_i ##1 ce_i |=> a_s == $past(pin_a_i, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("sync depth wrong");

   // Ack is a single-cycle pulse one cycle after request.
   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      (ce_i && req) |=> ack_o ##1 (!ack_o || !ce_i);
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing wrong");

endmodule // pio_ports

// >>> pkg/pio_pkg.sv
// Purpose: Shared constants and carriers for the parallel port block.
// Assumes: Classic Wishbone slave, 32-bit data, word-indexed registers.
// Notes:   Register indices are multiplied by four to form byte addresses.
package pio_pkg;

   // Register indices as printed, and of our own for unprinted ones.
   localparam logic [7:0] IDX_PORT_A_LATCH = 8'h00;
   localparam logic [7:0] IDX_PORT_B_LATCH = 8'h01;
   localparam logic [7:0] IDX_PORT_C_LATCH = 8'h02;
   localparam logic [7:0] IDX_PORT_D_LATCH = 8'h03;
   localparam logic [7:0] IDX_PORT_A_DIR   = 8'h04;
   localparam logic [7:0] IDX_PORT_B_DIR   = 8'h05;
   localparam logic [7:0] IDX_PORT_C_DIR   = 8'h06;
   localparam logic [7:0] IDX_PORT_D_DIR   = 8'h07;

   // Port widths.
   localparam int A_W = 7;
   localparam int B_W = 8;
   localparam int C_W = 5;
   localparam int D_W = 2;

   // Field positions and the converter select width.
   localparam int CLK_OUT_BIT  = 7;
   localparam int CLK_OUT_PIN  = 2;
   localparam int TIMER_B_LSB  = 6;
   localparam int CONV_SEL_W   = 5;

   // Reset values of direction registers.
   localparam logic [7:0] DIR_RESET = 8'h00;

   // Pin pair of one port: output level and output enable.
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pio_drive_type;

endpackage

// >>> dv/pio_pin_model.sv
// Purpose: Far-side model of one port's pins, resolving each wire level.
// Assumes: Output enable high means the block drives that pin.
// Notes:   Undriven pins take the level that the external device applies.
`timescale 1ns/1ps

module pio_pin_model
#(
   parameter int W = 8
)
(
   // Block side.
   input  wire logic [W-1:0] out_i,
   input  wire logic [W-1:0] oe_i,
   // External device side.
   input  wire logic [W-1:0] ext_i,
   // Resolved wire levels.
   output logic      [W-1:0] pin_o
);

   // A driven pin shows the block's level, a floating one the device's.
   always_comb
   begin
      for (int k = 0; k < W; k++)
      begin
         pin_o[k] = oe_i[k] ? out_i[k] : ext_i[k];
      end
   end

endmodule // pio_pin_model

// >>> dv/pio_ports_tb.sv
// Purpose: Self-checking bench for the parallel port block.
// Assumes: Wishbone answer one cycle after a request is taken.
// Notes:   Pin reads are given four cycles to pass the synchroniser.
`timescale 1ns/1ps

module pio_ports_tb;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce = 1'b1;
   logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [9:0]  adr_i = 10'h000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic [4:0]  csel = 5'h00;
   logic        cact = 1'b0, sysclk = 1'b0;
   logic [1:0]  tbs = 2'h0, tas = 2'h0, tbo = 2'h0, tao = 2'h0;
   logic [1:0]  tboe = 2'h0, taoe = 2'h0, tbl, tal;
   logic [7:0]  ext_a = 8'h00, ext_b = 8'h00, ext_c = 8'h00, ext_d = 8'h00;
   logic [6:0]  pa, pao, paoe;
   logic [7:0]  pb, pbo, pboe, csel_o;
   logic [4:0]  pc, pco, pcoe;
   logic [1:0]  pd, pdo, pdoe;
   logic [7:0]  oe_v [4];
   logic [7:0]  out_v [4];
   logic [7:0]  rd;
   int          fails = 0;
   int          checks = 0;

   // Clock at 40 MHz.
   always #12.5 clk_i = ~clk_i;

   // Per-port views of the pin drive for indexed checks.
   assign oe_v[0] = {1'b0, paoe};
   assign oe_v[1] = pboe;
   assign oe_v[2] = {3'h0, pcoe};
   assign oe_v[3] = {6'h00, pdoe};
   assign out_v[0] = {1'b0, pao};
   assign out_v[1] = pbo;
   assign out_v[2] = {3'h0, pco};
   assign out_v[3] = {6'h00, pdo};

   pio_ports i_pio_ports (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .converter_channel_select_i(csel), .converter_active_i(cact),
      .timer_b_edge_level_select_i(tbs), .timer_a_edge_level_select_i(tas),
      .timer_b_channel_pins_out_i(tbo), .timer_a_channel_pins_out_i(tao),
      .timer_b_channel_pins_oe_i(tboe), .timer_a_channel_pins_oe_i(taoe),
      .sys_clk_level_i(sysclk), .pin_a_i(pa), .pin_b_i(pb), .pin_c_i(pc),
      .pin_d_i(pd), .pin_a_o(pao), .pin_a_oe_o(paoe), .pin_b_o(pbo),
      .pin_b_oe_o(pboe), .pin_c_o(pco), .pin_c_oe_o(pcoe), .pin_d_o(pdo),
      .pin_d_oe_o(pdoe), .converter_pin_sel_o(csel_o),
      .timer_b_pin_level_o(tbl), .timer_a_pin_level_o(tal));

   pio_pin_model #(.W(7)) i_pio_pin_model_a (.out_i(pao), .oe_i(paoe),
      .ext_i(ext_a[6:0]), .pin_o(pa));
   pio_pin_model #(.W(8)) i_pio_pin_model_b (.out_i(pbo), .oe_i(pboe),
      .ext_i(ext_b), .pin_o(pb));
   pio_pin_model #(.W(5)) i_pio_pin_model_c (.out_i(pco), .oe_i(pcoe),
      .ext_i(ext_c[4:0]), .pin_o(pc));
   pio_pin_model #(.W(2)) i_pio_pin_model_d (.out_i(pdo), .oe_i(pdoe),
      .ext_i(ext_d[1:0]), .pin_o(pd));

   // Prints the verdict and ends the run.
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d.", checks, fails);
      if (fails == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Compares one value with its expectation.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One classic Wishbone cycle; the read byte lands in rd.
   task automatic wb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      sel_i <= 4'h1;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, wd};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1)
      begin
         fails++;
         finish_test();
      end
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic settle();
      repeat (4) @(posedge clk_i);
   endtask

   // Direction registers and drive are clear after reset.
   task automatic t_reset();
      for (int i = 4; i < 8; i++)
      begin
         wb(1'b0, 8'(i), 8'h00);
         chk({24'h0, rd}, 32'h0);
      end
      chk({paoe, pboe, pcoe, pdoe}, 32'h0);
      $display("Test reset done.");
   endtask

   // Latch, direction, drive and read mux of every port.
   task automatic t_ports();
      logic [7:0] m;
      for (int p = 0; p < 4; p++)
      begin
         m = (p == 0) ? 8'h7f : (p == 1) ? 8'hff : (p == 2) ? 8'h1f : 8'h03;
         ext_a <= 8'h5a;
         ext_b <= 8'h5a;
         ext_c <= 8'h5a;
         ext_d <= 8'h5a;
         wb(1'b1, 8'(p), 8'ha5);
         settle();
         wb(1'b0, 8'(p), 8'h00);
         chk({24'h0, rd}, {24'h0, 8'h5a & m});
         chk({24'h0, oe_v[p]}, 32'h0);
         wb(1'b1, 8'(p + 4), 8'h0f);
         settle();
         wb(1'b0, 8'(p), 8'h00);
         chk({24'h0, rd}, {24'h0, 8'h55 & m});
         chk({24'h0, oe_v[p]}, {24'h0, 8'h0f & m});
         chk({24'h0, out_v[p] & 8'h0f}, {24'h0, 8'h05 & m});
      end
      $display("Test ports done.");
   endtask

   // A second reset clears directions but keeps latches.
   task automatic t_rerun();
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({paoe, pboe, pcoe, pdoe}, 32'h0);
      wb(1'b1, 8'h04, 8'h7f);
      wb(1'b0, 8'h00, 8'h00);
      chk({24'h0, rd}, 32'h25);
      $display("Test second reset done.");
   endtask

   // Converter takes port B pin 6 away from general use.
   task automatic t_conv();
      ext_b <= 8'hff;
      wb(1'b1, 8'h01, 8'hff);
      wb(1'b1, 8'h05, 8'h40);
      csel <= 5'h06;
      cact <= 1'b1;
      settle();
      chk({24'h0, csel_o}, 32'h40);
      chk({31'h0, pboe[6]}, 32'h0);
      wb(1'b0, 8'h01, 8'h00);
      chk({24'h0, rd}, 32'hff);
      wb(1'b1, 8'h05, 8'h00);
      settle();
      wb(1'b0, 8'h01, 8'h00);
      chk({24'h0, rd}, 32'hbf);
      cact <= 1'b0;
      $display("Test converter done.");
   endtask

   // Timer channels own port B 6 and port D 1.
   task automatic t_timer();
      tbs  <= 2'b01;
      tbo  <= 2'b01;
      tboe <= 2'b01;
      tas  <= 2'b10;
      ext_d <= 8'h02;
      wb(1'b1, 8'h01, 8'h00);
      wb(1'b1, 8'h07, 8'h03);
      settle();
      chk({30'h0, pboe[6], pbo[6]}, 32'h3);
      chk({30'h0, pdoe}, 32'h1);
      chk({30'h0, tal}, 32'h2);
      wb(1'b0, 8'h01, 8'h00);
      chk({31'h0, rd[6]}, 32'h1);
      wb(1'b1, 8'h05, 8'h40);
      settle();
      wb(1'b0, 8'h01, 8'h00);
      chk({31'h0, rd[6]}, 32'h0);
      chk({31'h0, pboe[6]}, 32'h1);
      $display("Test timer done.");
   endtask

   // Clock output on port C pin 2, and an unmapped read.
   task automatic t_clk();
      wb(1'b1, 8'h06, 8'h80);
      sysclk <= 1'b1;
      settle();
      chk({30'h0, pcoe[2], pco[2]}, 32'h3);
      sysclk <= 1'b0;
      settle();
      chk({30'h0, pcoe[2], pco[2]}, 32'h2);
      // With the clock enable low the pin drive must stay frozen.
      ce     <= 1'b0;
      sysclk <= 1'b1;
      settle();
      chk({30'h0, pcoe[2], pco[2]}, 32'h2);
      ce     <= 1'b1;
      settle();
      chk({30'h0, pcoe[2], pco[2]}, 32'h3);
      sysclk <= 1'b0;
      wb(1'b0, 8'h06, 8'h00);
      chk({24'h0, rd}, 32'h80);
      wb(1'b0, 8'h20, 8'h00);
      chk({24'h0, rd}, 32'h0);
      $display("Test clock output done.");
   endtask

   // Main sequence.
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_ports();
      t_rerun();
      t_conv();
      t_timer();
      t_clk();
      finish_test();
   end

endmodule // pio_ports_tb
